// File: design/io_space_pkg.sv
// Purpose: Shared constants and types for the I/O register space decoder
// Assumes: Register addresses are data-space addresses (I/O + 0x20)
// Notes: One descriptor per implemented register; masks shape access
package io_space_pkg;

  // ----------------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------------
  localparam int NUM_REGS = 44;
  localparam int REG_IDX_W = 6;
  localparam int IO_ADDR_W = 6;
  localparam int DATA_ADDR_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam logic [7:0] IO_TO_DATA_OFFSET = 8'h20;
  localparam logic [5:0] BIT_OP_IO_LAST = 6'h1F;
  localparam logic [7:0] IO_WINDOW_DATA_FIRST = 8'h20;
  localparam logic [7:0] EXT_DATA_FIRST = 8'h60;
  localparam logic [7:0] EXT_DATA_LAST = 8'hFF;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] BIT_ZERO_ONEHOT = 8'h01;

  // ----------------------------------------------------------------------
  // Access kinds seen by the decoder
  // ----------------------------------------------------------------------
  // Direct and displaced load/store forms arrive as the plain load/store
  typedef enum logic [7:0] {
    io_read_op = 8'h01,
    io_write_op = 8'h02,
    data_space_load_op = 8'h04,
    data_space_store_op = 8'h08,
    set_io_bit_op = 8'h10,
    clear_io_bit_op = 8'h20,
    skip_if_io_bit_one_op = 8'h40,
    skip_if_io_bit_zero_op = 8'h80
  } op_type;

  typedef struct packed {
    logic valid;
    op_type op;
    logic [DATA_ADDR_W-1:0] addr;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [7:0] wdata;
  } request_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] rdata;
    logic bit_value;
    logic skip;
  } response_type;

  // addr, readable, writable, write-one-to-clear, live input, hw-set
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] rd_mask;
    logic [7:0] wr_mask;
    logic [7:0] w1c_mask;
    logic [7:0] live_mask;
    logic [7:0] set_mask;
  } reg_desc_type;

  // ----------------------------------------------------------------------
  // Register descriptors
  // ----------------------------------------------------------------------
  localparam reg_desc_type REG_TABLE [NUM_REGS] = '{
    '{8'h23, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00}, // port_b_pin_input
    '{8'h24, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // port_b_direction
    '{8'h25, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // port_b_output
    '{8'h26, 8'h7F, 8'h00, 8'h00, 8'h7F, 8'h00}, // port_c_pin_input
    '{8'h27, 8'h7F, 8'h7F, 8'h00, 8'h00, 8'h00}, // port_c_direction
    '{8'h28, 8'h7F, 8'h7F, 8'h00, 8'h00, 8'h00}, // port_c_output
    '{8'h29, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00}, // port_d_pin_input
    '{8'h2A, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // port_d_direction
    '{8'h2B, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // port_d_output
    '{8'h35, 8'h07, 8'h07, 8'h07, 8'h00, 8'h07}, // timer0_flags
    '{8'h36, 8'h27, 8'h27, 8'h27, 8'h00, 8'h27}, // timer1_flags
    '{8'h37, 8'h07, 8'h07, 8'h07, 8'h00, 8'h07}, // timer2_flags
    '{8'h3B, 8'h07, 8'h07, 8'h07, 8'h00, 8'h07}, // pin_change_flags
    '{8'h3C, 8'h03, 8'h03, 8'h03, 8'h00, 8'h03}, // external_irq_flags
    '{8'h3D, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00}, // external_irq_mask
    '{8'h3E, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // scratch_reg_0
    '{8'h3F, 8'h3F, 8'h3F, 8'h00, 8'h00, 8'h00}, // nvm_data_control
    '{8'h40, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // nvm_data_byte
    '{8'h41, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // nvm_address_low
    '{8'h42, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // nvm_address_high
    '{8'h43, 8'h83, 8'h83, 8'h00, 8'h00, 8'h00}, // prescaler_sync_control
    '{8'h44, 8'hF3, 8'hF3, 8'h00, 8'h00, 8'h00}, // timer0_control_a
    '{8'h45, 8'hCF, 8'hCF, 8'h00, 8'h00, 8'h00}, // timer0_control_b
    '{8'h46, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // timer0_count
    '{8'h47, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // timer0_compare_a
    '{8'h48, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // timer0_compare_b
    '{8'h4A, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // scratch_reg_1
    '{8'h4B, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // scratch_reg_2
    '{8'h4C, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // serial_periph_control
    '{8'h4D, 8'hC1, 8'h01, 8'h00, 8'h00, 8'hC0}, // serial_periph_status
    '{8'h4E, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // serial_periph_data
    '{8'h50, 8'hFF, 8'hDF, 8'h10, 8'h20, 8'h10}, // comparator_ctrl_stat
    '{8'h53, 8'h0F, 8'h0F, 8'h00, 8'h00, 8'h00}, // sleep_control
    '{8'h54, 8'h0F, 8'h0F, 8'h00, 8'h00, 8'h0F}, // reset_cause_flags
    '{8'h55, 8'h73, 8'h73, 8'h00, 8'h00, 8'h00}, // core_misc_control
    '{8'h57, 8'hDF, 8'h9F, 8'h00, 8'h40, 8'h00}, // self_program_control
    '{8'h5D, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // stack_pointer_low
    '{8'h5E, 8'h07, 8'h07, 8'h00, 8'h00, 8'h00}, // stack_pointer_high
    '{8'h5F, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // cpu_status_flags
    '{8'h60, 8'hFF, 8'h7F, 8'h80, 8'h00, 8'h80}, // watchdog_ctrl_stat
    '{8'h61, 8'h8F, 8'h8F, 8'h00, 8'h00, 8'h00}, // clock_divider_control
    '{8'h64, 8'hEF, 8'hEF, 8'h00, 8'h00, 8'h00}, // power_reduction
    '{8'h66, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, // rc_oscillator_trim
    '{8'h68, 8'h07, 8'h07, 8'h00, 8'h00, 8'h00}  // pin_change_irq_enable
  };

endpackage

// File: design/io_register_space_decoder.sv
// Purpose: Lower I/O register space of an 8-bit controller, as seen by
//          the core's load/store, I/O and single-bit accesses
// Assumes: One request per cycle; inputs synchronous to clk_in
// Notes: Answer comes one cycle after the request; peripherals sit outside

// How it works
// - Bit set/clear works on I/O 0x00-0x1F
// - Bit tests return one selected bit
// - Flags clear on written one, zero ignored
// - Bit ops never clear other pending flags
// - Bit ops outside 0x00-0x1F do nothing
// - I/O accesses use a six-bit address
// - Data address equals I/O address plus 0x20
// - Extended range reachable by load/store only
module io_register_space_decoder
  import io_space_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire request_type req_in,
  input wire logic [NUM_REGS-1:0][7:0] hw_level_in,
  input wire logic [NUM_REGS-1:0][7:0] hw_set_in,
  output response_type resp_out,
  output logic [NUM_REGS-1:0][7:0] reg_image_out
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------

  // Table search; the hit flag sits in the top bit
  function automatic logic [REG_IDX_W:0] find_reg(
    input logic [DATA_ADDR_W-1:0] daddr
  );
    logic [REG_IDX_W:0] res;
    res = '0;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (REG_TABLE[k].addr == daddr) begin
        res = {1'b1, REG_IDX_W'(k)};
      end
    end
    return res;
  endfunction

  // Visible value: stored bits, live pins merged, reserved bits zero
  function automatic logic [7:0] visible_value(
    input logic [7:0] stored,
    input logic [7:0] live,
    input reg_desc_type desc
  );
    logic [7:0] merged;
    merged = (stored & ~desc.live_mask) | (live & desc.live_mask);
    return merged & desc.rd_mask;
  endfunction

  function automatic logic is_io_op(input op_type op);
    return (op == io_read_op) || (op == io_write_op);
  endfunction

  function automatic logic is_bit_op(input op_type op);
    return (op == set_io_bit_op) || (op == clear_io_bit_op) ||
           (op == skip_if_io_bit_one_op) ||
           (op == skip_if_io_bit_zero_op);
  endfunction

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  logic [IO_ADDR_W-1:0] io_addr;
  logic [DATA_ADDR_W-1:0] data_addr;
  logic [REG_IDX_W:0] found;
  logic hit;
  logic [REG_IDX_W-1:0] idx;
  logic bit_range_ok;
  logic addr_legal;
  logic byte_write;
  logic byte_read;
  logic bit_set;
  logic bit_clear;
  logic bit_test;
  logic [7:0] bit_onehot;
  logic [NUM_REGS-1:0][7:0] regs_q;

  always_comb begin
    io_addr = req_in.addr[IO_ADDR_W-1:0];
    if (is_io_op(req_in.op) || is_bit_op(req_in.op)) begin
      // I/O forms map onto the same register as data space
      data_addr = {2'b00, io_addr} + IO_TO_DATA_OFFSET;
    end else begin
      data_addr = req_in.addr;
    end
  end

  always_comb begin
    found = find_reg(data_addr);
    hit = found[REG_IDX_W];
    idx = found[REG_IDX_W-1:0];
  end

  // Six-bit I/O field never reaches 0x60 and up
  always_comb begin
    bit_range_ok = (io_addr <= BIT_OP_IO_LAST);
    if (is_bit_op(req_in.op)) begin
      addr_legal = bit_range_ok;
    end else if (is_io_op(req_in.op)) begin
      addr_legal = (data_addr < EXT_DATA_FIRST);
    end else begin
      addr_legal = (data_addr >= IO_WINDOW_DATA_FIRST) &&
                   (data_addr <= EXT_DATA_LAST);
    end
  end

  always_comb begin
    byte_write = 1'b0;
    byte_read = 1'b0;
    bit_set = 1'b0;
    bit_clear = 1'b0;
    bit_test = 1'b0;
    if (req_in.valid && addr_legal) begin
      case (req_in.op)
        io_write_op: byte_write = 1'b1;
        data_space_store_op: byte_write = 1'b1;
        io_read_op: byte_read = 1'b1;
        data_space_load_op: byte_read = 1'b1;
        set_io_bit_op: bit_set = 1'b1;
        clear_io_bit_op: bit_clear = 1'b1;
        skip_if_io_bit_one_op: bit_test = 1'b1;
        skip_if_io_bit_zero_op: bit_test = 1'b1;
        default: byte_read = 1'b0;
      endcase
    end
  end

  always_comb begin
    bit_onehot = BIT_ZERO_ONEHOT << req_in.bit_sel;
  end

  // ----------------------------------------------------------------------
  // Register storage, two flop sets per descriptor (state and image copy)
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      logic sel;
      logic [7:0] wr_bits;
      logic [7:0] clr_bits;
      logic [7:0] keep_bits;
      logic [7:0] plain_mask;
      logic [7:0] reg_d;

      always_comb begin
        sel = hit && (idx == REG_IDX_W'(g));
        plain_mask = REG_TABLE[g].wr_mask & ~REG_TABLE[g].w1c_mask;
        keep_bits = regs_q[g];
        wr_bits = 8'h00;
        clr_bits = 8'h00;
        if (sel && byte_write) begin
          // Reserved bits keep zero whatever is written
          keep_bits = regs_q[g] & ~plain_mask;
          wr_bits = req_in.wdata & plain_mask;
          clr_bits = req_in.wdata & REG_TABLE[g].w1c_mask;
        end else if (sel && bit_set) begin
          // Only the addressed bit moves; other flags stay pending
          wr_bits = bit_onehot & plain_mask;
          clr_bits = bit_onehot & REG_TABLE[g].w1c_mask;
        end else if (sel && bit_clear) begin
          // Writing zero to a flag bit leaves it alone
          keep_bits = regs_q[g] & ~(bit_onehot & plain_mask);
        end
        // Hardware event wins over a clear in the same cycle
        reg_d = ((keep_bits | wr_bits) & ~clr_bits) |
                (hw_set_in[g] & REG_TABLE[g].set_mask);
      end

      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          regs_q[g] <= RESET_VALUE;
        end else begin
          regs_q[g] <= reg_d;
        end
      end

      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          reg_image_out[g] <= RESET_VALUE;
        end else begin
          reg_image_out[g] <= reg_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] read_value;
  logic selected_bit;
  logic want_one;

  // Unmapped or reserved locations simply read as zero
  always_comb begin
    read_value = 8'h00;
    if (hit) begin
      read_value = visible_value(regs_q[idx], hw_level_in[idx],
                                 REG_TABLE[idx]);
    end
  end

  always_comb begin
    selected_bit = read_value[req_in.bit_sel];
    want_one = (req_in.op == skip_if_io_bit_one_op);
  end

  // ----------------------------------------------------------------------
  // Answer register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_out <= '0;
    end else begin
      resp_out.valid <= req_in.valid;
      resp_out.hit <= req_in.valid && addr_legal && hit;
      resp_out.rdata <= byte_read ? read_value : 8'h00;
      resp_out.bit_value <= bit_test && selected_bit;
      resp_out.skip <= bit_test && (selected_bit == want_one);
    end
  end

  // Stores to reserved locations fall through the table search and are
  // dropped, so a stray write cannot disturb a neighbour

endmodule // io_register_space_decoder

// File: verification/io_space_properties.sv
// Purpose: Port checks for the I/O register space decoder
// Assumes: Answer one cycle after a taken request
// Notes: Flag clear checks skip cycles with a hardware event; a_event_wins checks them
module io_space_properties
  import io_space_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire request_type req_in,
  input wire logic [NUM_REGS-1:0][7:0] hw_level_in,
  input wire logic [NUM_REGS-1:0][7:0] hw_set_in,
  input wire response_type resp_out,
  input wire logic [NUM_REGS-1:0][7:0] reg_image_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_answer_follows: assert property (
    req_in.valid |=> resp_out.valid) else $error("answer missing");
  a_miss_reads_zero: assert property (
    resp_out.valid && !resp_out.hit |-> resp_out.rdata == 8'h00)
    else $error("miss returned data");
  a_skip_one_test: assert property (
    req_in.valid && req_in.op == skip_if_io_bit_one_op
    |=> resp_out.skip == resp_out.bit_value) else $error("skip one wrong");
  a_skip_zero_test: assert property (
    req_in.valid && req_in.op == skip_if_io_bit_zero_op
    |=> !resp_out.hit || resp_out.skip != resp_out.bit_value)
    else $error("skip zero wrong");
  a_bitop_range_dead: assert property (
    req_in.valid && req_in.op inside {set_io_bit_op, clear_io_bit_op} &&
    req_in.addr[5:0] > BIT_OP_IO_LAST && hw_set_in == '0
    |=> reg_image_out == $past(reg_image_out) && !resp_out.hit)
    else $error("bit op outside range acted");
  a_flag_write_clear: assert property (
    req_in.valid && req_in.op == io_write_op && req_in.addr[5:0] == 6'h15
    && hw_set_in[9] == 8'h00 |=> reg_image_out[9] ==
    ($past(reg_image_out[9]) & ~$past(req_in.wdata)))
    else $error("flag clear wrong");
  a_bit_set_flag: assert property (
    req_in.valid && req_in.op == set_io_bit_op && req_in.addr[5:0] == 6'h15
    && hw_set_in[9] == 8'h00 |=> reg_image_out[9] ==
    ($past(reg_image_out[9]) & ~(8'h01 << $past(req_in.bit_sel))))
    else $error("bit op touched other flags");
  a_store_maps_io: assert property (
    req_in.valid && req_in.op == data_space_store_op && req_in.addr == 8'h25
    |=> reg_image_out[2] == $past(req_in.wdata)) else $error("store map");
  a_ext_store: assert property (
    req_in.valid && req_in.op == data_space_store_op && req_in.addr == 8'h66
    |=> reg_image_out[42] == $past(req_in.wdata)) else $error("ext store");
  a_bit_clear_plain: assert property (
    req_in.valid && req_in.op == clear_io_bit_op && req_in.addr[5:0] == 6'h04
    |=> reg_image_out[1] ==
    ($past(reg_image_out[1]) & ~(8'h01 << $past(req_in.bit_sel))))
    else $error("bit clear wrong");
  a_event_wins: assert property (
    hw_set_in[9] != 8'h00 |=> (reg_image_out[9] & $past(hw_set_in[9]) &
    8'h07) == ($past(hw_set_in[9]) & 8'h07)) else $error("flag event lost");
endmodule // io_space_properties

bind io_register_space_decoder io_space_properties chk (
  .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
  .hw_level_in(hw_level_in), .hw_set_in(hw_set_in),
  .resp_out(resp_out), .reg_image_out(reg_image_out));

// File: verification/core_model.sv
// Purpose: Core side that issues register accesses
// Assumes: Inputs change at the falling edge
// Notes: Idle address is scrambled so stale values are not trusted
module core_model
  import io_space_pkg::*;
(
  input wire logic clk_in,
  input wire response_type resp_in,
  output request_type req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  response_type last;
  initial req_out = '0;
  // Two cycles per request (one valid, one idle), eight-bit address passed as given
  // Callers keep reserved bits zero, no reserved writes
  task automatic issue(input op_type op, input logic [7:0] addr,
                       input logic [2:0] bsel, input logic [7:0] wdata);
    @(negedge clk_in);
    req_out <= '{1'b1, op, addr, bsel, wdata};
    @(negedge clk_in);
    last = resp_in;
    req_out.valid <= 1'b0;
    req_out.addr <= ~addr;
  endtask
endmodule // core_model

// File: verification/io_register_space_decoder_tb.sv
// Purpose: Self-checking bench for the I/O register space decoder
// Assumes: Answer and register update one cycle after the request
// Notes: All live inputs held high to expose reserved bits
module io_register_space_decoder_tb
  import io_space_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  request_type req;
  response_type resp;
  logic [NUM_REGS-1:0][7:0] hw_level = '1;
  logic [NUM_REGS-1:0][7:0] hw_set = '0;
  logic [NUM_REGS-1:0][7:0] image;
  int bad_count = 0;
  int checks_done = 0;
  always #25 clk_in = ~clk_in;
  io_register_space_decoder dut (.clk_in(clk_in), .rst_in(rst_in),
    .req_in(req), .hw_level_in(hw_level), .hw_set_in(hw_set),
    .resp_out(resp), .reg_image_out(image));
  core_model core (.clk_in(clk_in), .resp_in(resp), .req_out(req));
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic addressing;
    chk(image[2], 8'h00);
    core.issue(data_space_store_op, 8'h25, 3'h0, 8'h3C);
    chk(image[2], 8'h3C);
    core.issue(io_write_op, 8'h05, 3'h0, 8'hA5);
    chk(image[2], 8'hA5);
    core.issue(data_space_load_op, 8'h25, 3'h0, 8'h00);
    chk(core.last.rdata, 8'hA5);
    core.issue(data_space_store_op, 8'h66, 3'h0, 8'h5A);
    chk(image[42], 8'h5A);
    core.issue(io_read_op, 8'h66, 3'h0, 8'h00);
    chk(core.last.rdata, 8'h00);
    core.issue(data_space_load_op, 8'h1F, 3'h0, 8'h00);
    chk({7'h00, core.last.hit}, 8'h00);
  endtask
  task automatic reserved_places;
    core.issue(io_read_op, 8'h06, 3'h0, 8'h00);
    chk(core.last.rdata, 8'h7F);
    core.issue(io_read_op, 8'h0C, 3'h0, 8'h00);
    chk(core.last.rdata, 8'h00);
    chk({7'h00, core.last.hit}, 8'h00);
  endtask
  task automatic flag_clearing;
    @(negedge clk_in);
    hw_set[9] = 8'h07;
    @(negedge clk_in);
    hw_set[9] = 8'h00;
    chk(image[9], 8'h07);
    core.issue(io_write_op, 8'h15, 3'h0, 8'h02);
    chk(image[9], 8'h05);
    core.issue(io_write_op, 8'h15, 3'h0, 8'h00);
    chk(image[9], 8'h05);
    core.issue(set_io_bit_op, 8'h15, 3'h0, 8'h00);
    chk(image[9], 8'h04);
    core.issue(clear_io_bit_op, 8'h15, 3'h2, 8'h00);
    chk(image[9], 8'h04);
    // Event and clear land on one edge; the event must survive
    fork
      core.issue(io_write_op, 8'h15, 3'h0, 8'h01);
      begin
        @(negedge clk_in);
        hw_set[9] = 8'h01;
        @(negedge clk_in);
        hw_set[9] = 8'h00;
      end
    join
    chk(image[9], 8'h05);
  endtask
  task automatic bit_access;
    core.issue(set_io_bit_op, 8'h04, 3'h3, 8'h00);
    chk(image[1], 8'h08);
    core.issue(set_io_bit_op, 8'h04, 3'h7, 8'h00);
    chk(image[1], 8'h88);
    core.issue(clear_io_bit_op, 8'h04, 3'h3, 8'h00);
    chk(image[1], 8'h80);
    core.issue(set_io_bit_op, 8'h20, 3'h0, 8'h00);
    chk(image[17], 8'h00);
    core.issue(set_io_bit_op, 8'h24, 3'h0, 8'h00);
    chk(image[21], 8'h00);
    core.issue(skip_if_io_bit_one_op, 8'h05, 3'h0, 8'h00);
    chk({7'h00, core.last.skip}, 8'h01);
    chk({7'h00, core.last.bit_value}, 8'h01);
    core.issue(skip_if_io_bit_one_op, 8'h05, 3'h1, 8'h00);
    chk({7'h00, core.last.skip}, 8'h00);
    core.issue(skip_if_io_bit_zero_op, 8'h05, 3'h1, 8'h00);
    chk({7'h00, core.last.skip}, 8'h01);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    addressing();
    reserved_places();
    flag_clearing();
    bit_access();
    end_of_test();
  end
  // Run needs about 50 cycles; generous margin
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    end_of_test();
  end
endmodule // io_register_space_decoder_tb
